// ===== dv/fan_pwm_override_spinup_ctrl_tb.sv
// Self-checking bench for the second fan output control block.
// Assumes fpo_pkg and the fan model are compiled before it.
`timescale 1ns/100ps
module fan_pwm_override_spinup_ctrl_tb;
    // ==================================================
    // Signals
    localparam int MS_T = 20;
    localparam int STEP = 2;
    localparam logic [7:0] CD = fpo_pkg::ADDR_OVR_LOCK;
    localparam logic [7:0] CE = fpo_pkg::ADDR_SPINUP;
    localparam logic [7:0] ROW_CTRL [6] = '{8'h51, 8'hA1, 8'hF1, 8'hF3, 8'h03, 8'h50};
    localparam logic [7:0] ROW_RD [6] = '{8'h51, 8'hA1, 8'hF1, 8'hF3, 8'h03, 8'h00};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic regWrEn = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic configLock = 1'b0;
    logic [5:0] srcBound = 6'h00;
    logic [23:0] srcDutyCode = 24'h0000;
    logic hotEventBound = 1'b0;
    logic processorHotEvent = 1'b0;
    logic fanPwmOut;
    logic spinupActive;
    logic [7:0] highCnt;
    int fails = 0;
    int total_checks = 0;
    int spinCnt = 0;
    int base;
    int n;
    int expLen;

    fpo_ctrl #(.NUM_SRC(6), .MS_TICK_CYCLES(MS_T), .PWM_STEP_CYCLES(STEP)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .configLock(configLock),
        .srcBound(srcBound), .srcDutyCode(srcDutyCode), .hotEventBound(hotEventBound),
        .processorHotEvent(processorHotEvent), .fanPwmOut(fanPwmOut), .spinupActive(spinupActive));
    fpo_fan_model #(.PERIOD(15 * STEP)) fan_i (.core_clk(core_clk), .pwmIn(fanPwmOut), .highCnt(highCnt));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (spinupActive === 1'b1) begin
            spinCnt <= spinCnt + 1;
        end
    end

    // ==================================================
    // Tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        chk("regRdData", {8'h00, exp}, {8'h00, regRdData});
    endtask
    // Two windows plus the output lag before the count is trusted
    task automatic fan(input int exp);
        repeat (70) @(posedge core_clk);
        chk("highCnt", 16'(exp), {8'h00, highCnt});
    endtask
    task automatic hot_pulse;
        @(posedge core_clk);
        processorHotEvent <= 1'b1;
        repeat (4) @(posedge core_clk);
        processorHotEvent <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==================================================
    // Sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(CD, fpo_pkg::RESET_OVR_LOCK);
        rd(CE, fpo_pkg::RESET_SPINUP);
        wr(8'hCF, 8'hFF);
        rd(8'hCF, fpo_pkg::READ_UNMAPPED);
        chk("fanPwmOut", 16'h0000, {15'h0000, fanPwmOut});
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            wr(CD, ROW_CTRL[i]);
            rd(CD, ROW_RD[i]);
            fan(ROW_CTRL[i][1] ? (15 - ROW_RD[i][7:4]) * STEP : ROW_RD[i][7:4] * STEP);
        end
        $display("test table done");
        wr(CD, 8'h21);
        srcBound <= 6'b001001;
        srcDutyCode <= 24'h00_9007;
        rd(CD, 8'h91);
        fan(9 * STEP);
        srcBound <= 6'h00;
        wr(CD, 8'h05);
        hot_pulse();
        rd(CD, 8'h05);
        fan(0);
        $display("test sources done");
        hotEventBound <= 1'b1;
        wr(CD, 8'h01);
        hot_pulse();
        rd(CD, 8'h01);
        wr(CD, 8'h05);
        hot_pulse();
        rd(CD, 8'hFD);
        fan(15 * STEP);
        configLock <= 1'b1;
        wr(CD, 8'h04);
        rd(CD, 8'h05);
        fan(0);
        configLock <= 1'b0;
        $display("test hot lock done");
        for (int c = 0; c < 2; c++) begin
            wr(CD, 8'h00);
            wr(CE, c == 0 ? 8'h20 : 8'h0C);
            wr(CD, 8'h31);
            repeat (3) @(posedge core_clk);
            #1;
            chk("spinupActive", 16'h0000, {15'h0000, spinupActive});
        end
        for (int d = 1; d <= 2; d++) begin
            wr(CD, 8'h00);
            wr(CE, 8'(d << 5) | 8'h0C);
            rd(CE, 8'(d << 5) | 8'h0C);
            base = spinCnt;
            wr(CD, 8'h31);
            repeat (3) @(posedge core_clk);
            #1;
            chk("spinupActive", 16'h0001, {15'h0000, spinupActive});
            rd(CD, 8'h01);
            fan(12 * STEP);
            for (n = 0; n < 30000 && spinupActive !== 1'b0; n++) begin
                @(posedge core_clk);
            end
            if (n == 30000) begin
                chk("spinTimeout", 16'h0000, 16'h0001);
                end_sim();
            end
            expLen = int'(fpo_pkg::SPIN_MS[d]) * MS_T;
            chk("spinLen", 16'h0001, {15'h0000, spinCnt - base >= expLen - MS_T - 2 &&
                spinCnt - base <= expLen + MS_T + 2});
            rd(CD, 8'h31);
            fan(3 * STEP);
        end
        $display("test spin-up done");
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(CD, fpo_pkg::RESET_OVR_LOCK);
        rd(CE, fpo_pkg::RESET_SPINUP);
        chk("spinupActive", 16'h0000, {15'h0000, spinupActive});
        chk("fanPwmOut", 16'h0000, {15'h0000, fanPwmOut});
        $display("test mid-run reset done");
        end_sim();
    end
endmodule // fan_pwm_override_spinup_ctrl_tb

// ===== dv/fpo_fan_model.sv
// Fan on the second fan output: integrates the drive over one PWM period.
// Assumes the waveform period is PERIOD cycles of core_clk.
`timescale 1ns/100ps
module fpo_fan_model #(
    parameter int PERIOD = 30
) (
    input wire logic core_clk,
    input wire logic pwmIn,
    output logic [7:0] highCnt
);
    // ==================================================
    // Drive measurement
    // Any whole period holds the same high count, so phase does not matter
    int phase = 0;
    int acc = 0;
    initial highCnt = 8'h00;
    always @(posedge core_clk) begin
        if (phase == PERIOD - 1) begin
            highCnt <= 8'(acc + int'(pwmIn));
            acc <= 0;
            phase <= 0;
        end else begin
            acc <= acc + int'(pwmIn);
            phase <= phase + 1;
        end
    end
endmodule // fpo_fan_model

// ===== rtl/fpo_ctrl.sv
// Second fan output control: override, polarity, hot lock, readback, spin-up.
// Assumes register strobes and bound source codes come from same-clock logic;
// the processor-hot event arrives asynchronously from a pin.
//
// Overview of operation
// - Override enable drives the manual duty code
// - Invert bit reverses output polarity for all duties
// - Hot event sets lock flag only when enabled
// - Hot lock flag forces full duty outside spin-up
// - Writing zero clears flag, normal duty resumes
// - Flag stays writable under the configuration lock
// - Four-bit manual code selects one of sixteen duties
// - Manual code read returns duty in use outside spin-up
// - Larger bound request shows in the readback
// - Readback is zero during spin-up
// - Spin-up duty code selects spin-up drive
// - Spin-up duty code zero disables spin-up
// - Duration code is bit 4 then bits 7:5
// - Zero to non-zero duty starts spin-up
// - Codes 0-7 map disabled through 4 s
// - Codes 8-15 map 6 s to 20 s
// - Largest bound source duty wins
`timescale 1ns/100ps
module fpo_ctrl #(
    parameter int NUM_SRC = 6,
    parameter int MS_TICK_CYCLES = fpo_pkg::MS_TICK_CYCLES,
    parameter int PWM_STEP_CYCLES = fpo_pkg::PWM_STEP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic configLock,
    input wire logic [NUM_SRC-1:0] srcBound,
    input wire logic [NUM_SRC*4-1:0] srcDutyCode,
    input wire logic hotEventBound,
    input wire logic processorHotEvent,
    output logic fanPwmOut,
    output logic spinupActive
);

    typedef struct packed {
        logic manualEn;
        logic invert;
        logic hotEn;
        logic hotFlag;
        logic [3:0] manualCode;
        logic [7:0] spinCtrl;
        logic hotSync1;
        logic hotSync2;
        logic hotPrev;
        logic normalWasZero;
        fpo_pkg::fpo_spin_e spinState;
        logic [14:0] spinMs;
        logic [17:0] msDiv;
        logic msTick;
        logic pwmOut;
        logic spinOut;
        logic [7:0] rdData;
    } fpo_state_s;

    fpo_state_s st_reg;
    fpo_state_s st_next;
    logic [3:0] boundMax;
    logic [3:0] normalDuty;
    logic [3:0] dutyInUse;
    logic [3:0] spinDutyCode;
    logic [3:0] spinDurCode;
    logic hotEdge;
    logic pwmLevel;
    logic wrCtrl2;
    logic wrCtrl3;

    // ========================================================
    // Helpers
    function automatic logic [3:0] maxCode(input logic [3:0] a, input logic [3:0] b);
        maxCode = (a > b) ? a : b;
    endfunction

    function automatic logic [14:0] spinMsOf(input logic [3:0] code);
        spinMsOf = fpo_pkg::SPIN_MS[code];
    endfunction

    // Unbound sources request nothing, so zero is the floor
    always_comb begin
        boundMax = fpo_pkg::DUTY_OFF;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (srcBound[i]) begin
                boundMax = maxCode(boundMax, srcDutyCode[i*4 +: 4]);
            end
        end
    end

    // ========================================================
    // Duty arbitration
    assign spinDutyCode = st_reg.spinCtrl[fpo_pkg::SPIN_DC_LSB +: 4];
    assign spinDurCode = {st_reg.spinCtrl[fpo_pkg::SPIN_DUR_MSB_BIT],
        st_reg.spinCtrl[fpo_pkg::SPIN_DUR_LSB +: 3]};
    assign hotEdge = st_reg.hotSync2 && !st_reg.hotPrev;
    assign wrCtrl2 = regWrEn && (regAddr == fpo_pkg::ADDR_OVR_LOCK);
    assign wrCtrl3 = regWrEn && (regAddr == fpo_pkg::ADDR_SPINUP);

    always_comb begin
        if (st_reg.hotFlag) begin
            normalDuty = fpo_pkg::DUTY_FULL;
        end else if (st_reg.manualEn) begin
            normalDuty = maxCode(st_reg.manualCode, boundMax);
        end else begin
            normalDuty = boundMax;
        end
        dutyInUse = (st_reg.spinState == fpo_pkg::SPIN_RUN) ? spinDutyCode : normalDuty;
    end

    // Waveform lags the duty code by two edges
    fpo_pwm_gen #(
        .STEP_CYCLES(PWM_STEP_CYCLES),
        .DUTY_STEPS(fpo_pkg::DUTY_STEPS)
    ) u_pwm (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .dutyCode(dutyInUse),
        .pwmLevel(pwmLevel)
    );

    // ========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        // Only the second stage feeds the edge detector
        st_next.hotSync1 = processorHotEvent;
        st_next.hotSync2 = st_reg.hotSync1;
        st_next.hotPrev = st_reg.hotSync2;
        st_next.pwmOut = pwmLevel ^ st_reg.invert;

        // Millisecond time base
        st_next.msTick = 1'b0;
        if (st_reg.msDiv == 18'(MS_TICK_CYCLES - 1)) begin
            st_next.msDiv = '0;
            st_next.msTick = 1'b1;
        end else begin
            st_next.msDiv = st_reg.msDiv + 18'h0_0001;
        end

        // Configuration lock freezes everything except the hot flag
        if (wrCtrl2 && !configLock) begin
            st_next.manualEn = regWrData[fpo_pkg::BIT_MANUAL_EN];
            st_next.invert = regWrData[fpo_pkg::BIT_INVERT];
            st_next.hotEn = regWrData[fpo_pkg::BIT_HOT_EN];
            st_next.manualCode = regWrData[fpo_pkg::MANUAL_CODE_LSB +: 4];
        end
        if (wrCtrl3 && !configLock) begin
            st_next.spinCtrl = regWrData;
        end
        if (wrCtrl2 && !regWrData[fpo_pkg::BIT_HOT_FLAG]) begin
            st_next.hotFlag = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (hotEdge && hotEventBound && st_reg.hotEn) begin
            st_next.hotFlag = 1'b1;
        end

        // Spin-up sequencing
        st_next.normalWasZero = (normalDuty == fpo_pkg::DUTY_OFF);
        unique case (st_reg.spinState)
            fpo_pkg::SPIN_IDLE: begin
                if (st_reg.normalWasZero && normalDuty != fpo_pkg::DUTY_OFF
                    && spinDurCode != 4'h0 && spinDutyCode != fpo_pkg::DUTY_OFF) begin
                    st_next.spinState = fpo_pkg::SPIN_RUN;
                    st_next.spinMs = spinMsOf(spinDurCode);
                    // A tick already due may still cut the first millisecond short
                    st_next.msDiv = '0;
                end
            end
            fpo_pkg::SPIN_RUN: begin
                if (spinDutyCode == fpo_pkg::DUTY_OFF || normalDuty == fpo_pkg::DUTY_OFF) begin
                    st_next.spinState = fpo_pkg::SPIN_IDLE;
                    st_next.spinMs = '0;
                end else if (st_reg.msTick) begin
                    if (st_reg.spinMs <= 15'h0001) begin
                        st_next.spinState = fpo_pkg::SPIN_IDLE;
                        st_next.spinMs = '0;
                    end else begin
                        st_next.spinMs = st_reg.spinMs - 15'h0001;
                    end
                end
            end
        endcase
        // Registered so the port comes straight from a flop
        st_next.spinOut = (st_next.spinState == fpo_pkg::SPIN_RUN);

        // Readback of the control registers
        // A read in the cycle of a write shows the old value
        if (regRdEn) begin
            unique case (regAddr)
                fpo_pkg::ADDR_OVR_LOCK: begin
                    st_next.rdData = {(st_reg.spinState == fpo_pkg::SPIN_RUN)
                        ? fpo_pkg::DUTY_OFF : normalDuty,
                        st_reg.hotFlag, st_reg.hotEn, st_reg.invert, st_reg.manualEn};
                end
                fpo_pkg::ADDR_SPINUP: st_next.rdData = st_reg.spinCtrl;
                default: st_next.rdData = fpo_pkg::READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.spinCtrl <= fpo_pkg::RESET_SPINUP;
            st_reg.spinState <= fpo_pkg::SPIN_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regRdData = st_reg.rdData;
    assign fanPwmOut = st_reg.pwmOut;
    assign spinupActive = st_reg.spinOut;

    // ========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ========================================================
    // Checks: hot lock
    a_hot_needs_enable: assert property ($rose(st_reg.hotFlag) |-> $past(st_reg.hotEn))
        else $error("Hot lock flag set while enable clear");
    a_hot_full_duty: assert property (st_reg.hotFlag && !spinupActive |-> dutyInUse == fpo_pkg::DUTY_FULL)
        else $error("Hot lock did not force full duty");
    a_hot_clear_write: assert property (wrCtrl2 && !regWrData[fpo_pkg::BIT_HOT_FLAG] && !hotEdge
        |=> !st_reg.hotFlag)
        else $error("Zero write did not clear hot lock");
    a_hot_clear_locked: assert property (configLock && wrCtrl2 && !regWrData[fpo_pkg::BIT_HOT_FLAG]
        && !hotEdge |=> !st_reg.hotFlag)
        else $error("Hot lock not clearable under configuration lock");
    a_hot_set_wins: assert property (hotEdge && hotEventBound && st_reg.hotEn
        |=> st_reg.hotFlag)
        else $error("Hot event did not set hot lock");
    a_hot_no_write: assert property (!st_reg.hotFlag && !(hotEdge && hotEventBound && st_reg.hotEn)
        |=> !st_reg.hotFlag)
        else $error("Hot lock set without a bound event");

    // ========================================================
    // Checks: duty selection and readback
    a_read_spin_zero: assert property (regRdEn && regAddr == fpo_pkg::ADDR_OVR_LOCK && spinupActive
        |=> regRdData[7:4] == fpo_pkg::DUTY_OFF)
        else $error("Duty readback nonzero during spin-up");
    a_read_duty_use: assert property (regRdEn && regAddr == fpo_pkg::ADDR_OVR_LOCK && !spinupActive
        |=> regRdData[7:4] == $past(dutyInUse))
        else $error("Duty readback differs from duty in use");
    a_ctrl3_readback: assert property (regRdEn && regAddr == fpo_pkg::ADDR_SPINUP
        |=> regRdData == $past(st_reg.spinCtrl))
        else $error("Spin-up control readback differs from stored value");
    a_override_floor: assert property (st_reg.manualEn && !spinupActive |-> dutyInUse >= st_reg.manualCode)
        else $error("Override duty not applied");
    a_manual_applied: assert property (st_reg.manualEn && !st_reg.hotFlag && !spinupActive
        && boundMax <= st_reg.manualCode |-> dutyInUse == st_reg.manualCode)
        else $error("Manual duty code not in use");
    a_lock_freeze: assert property (configLock && wrCtrl2
        |=> st_reg.manualCode == $past(st_reg.manualCode))
        else $error("Manual duty code written under configuration lock");
    a_bound_max: assert property (!spinupActive |-> dutyInUse >= boundMax)
        else $error("Bound source request not honoured");

    // ========================================================
    // Checks: spin-up
    a_spin_starts: assert property (!spinupActive && st_reg.normalWasZero && normalDuty != fpo_pkg::DUTY_OFF
        && spinDurCode != 4'h0 && spinDutyCode != fpo_pkg::DUTY_OFF |=> spinupActive)
        else $error("Spin-up did not start on zero to nonzero");
    a_spin_zero_dc: assert property (spinDutyCode == fpo_pkg::DUTY_OFF && $stable(spinDutyCode)
        |=> !spinupActive)
        else $error("Spin-up ran with zero spin duty");
    a_spin_abort: assert property (spinupActive && (spinDutyCode == fpo_pkg::DUTY_OFF
        || normalDuty == fpo_pkg::DUTY_OFF) |=> !spinupActive)
        else $error("Spin-up kept running with a zero duty");
    a_spin_load: assert property ($rose(spinupActive)
        |-> st_reg.spinMs == spinMsOf($past(spinDurCode)))
        else $error("Spin-up duration not loaded from its code");
    a_spin_duty_use: assert property (spinupActive |-> dutyInUse == spinDutyCode)
        else $error("Spin-up duty code not in use");
    a_spin_expire: assert property (spinupActive && st_reg.msTick && st_reg.spinMs <= 15'h0001
        |=> !spinupActive)
        else $error("Spin-up did not end at expiry");

    // ========================================================
    // Checks: output polarity
    a_invert_full: assert property ((dutyInUse == fpo_pkg::DUTY_FULL && $stable(st_reg.invert))[*3]
        |-> fanPwmOut == !st_reg.invert)
        else $error("Full duty output level wrong for polarity");
    a_invert_zero: assert property ((dutyInUse == fpo_pkg::DUTY_OFF && $stable(st_reg.invert))[*3]
        |-> fanPwmOut == st_reg.invert)
        else $error("Zero duty output level wrong for polarity");

    // ========================================================
    // Scenario covers
    c_hot_lock: cover property ($rose(st_reg.hotFlag));
    c_spin_expire: cover property (spinupActive && st_reg.msTick ##1 !spinupActive);
    c_override_read: cover property (regRdEn && regAddr == fpo_pkg::ADDR_OVR_LOCK && st_reg.manualEn);
    c_spin_start: cover property ($rose(spinupActive));
    c_locked_clear: cover property (configLock && wrCtrl2 && st_reg.hotFlag ##1 !st_reg.hotFlag);

endmodule // fpo_ctrl

// ===== rtl/fpo_pkg.sv
// Constants shared by the second fan output control block.
// Assumes a single 200 MHz core clock and the documented register offsets.
package fpo_pkg;

    // ========================================================
    // Register map
    localparam logic [7:0] ADDR_OVR_LOCK = 8'hCD;
    localparam logic [7:0] ADDR_SPINUP = 8'hCE;
    localparam logic [7:0] RESET_OVR_LOCK = 8'h00;
    localparam logic [7:0] RESET_SPINUP = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ========================================================
    // Field positions
    localparam int BIT_MANUAL_EN = 0;
    localparam int BIT_INVERT = 1;
    localparam int BIT_HOT_EN = 2;
    localparam int BIT_HOT_FLAG = 3;
    localparam int MANUAL_CODE_LSB = 4;
    localparam int SPIN_DC_LSB = 0;
    localparam int SPIN_DUR_MSB_BIT = 4;
    localparam int SPIN_DUR_LSB = 5;

    // ========================================================
    // Duty codes
    localparam logic [3:0] DUTY_OFF = 4'h0;
    localparam logic [3:0] DUTY_FULL = 4'hF;
    localparam int DUTY_STEPS = 15;

    // ========================================================
    // Timing
    localparam int CLK_FREQ_MHZ = 200;
    localparam int MS_TIME_US = 1000;
    localparam int MS_TICK_CYCLES = MS_TIME_US * CLK_FREQ_MHZ;
    localparam int PWM_PERIOD_US = 40;
    localparam int PWM_STEP_CYCLES = (PWM_PERIOD_US * CLK_FREQ_MHZ) / DUTY_STEPS;

    // Spin-up duration in ms per duration code
    localparam logic [14:0] SPIN_MS [16] = '{
        15'd0, 15'd100, 15'd250, 15'd400, 15'd700, 15'd1000, 15'd2000, 15'd4000,
        15'd6000, 15'd8000, 15'd10000, 15'd12000, 15'd14000, 15'd16000, 15'd18000, 15'd20000};

    typedef enum logic {SPIN_IDLE, SPIN_RUN} fpo_spin_e;

endpackage

// ===== rtl/fpo_pwm_gen.sv
// Duty-code to waveform generator for the second fan output.
// Assumes dutyCode from logic on the same clock; output is not inverted here.
`timescale 1ns/100ps
module fpo_pwm_gen #(
    parameter int STEP_CYCLES = fpo_pkg::PWM_STEP_CYCLES,
    parameter int DUTY_STEPS = fpo_pkg::DUTY_STEPS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] dutyCode,
    output logic pwmLevel
);

    typedef struct packed {
        logic [15:0] stepDiv;
        logic [3:0] phase;
        logic level;
    } fpo_pwm_s;

    fpo_pwm_s st_reg;
    fpo_pwm_s st_next;

    // ========================================================
    // Phase stepping
    always_comb begin
        st_next = st_reg;
        if (st_reg.stepDiv == 16'(STEP_CYCLES - 1)) begin
            st_next.stepDiv = '0;
            st_next.phase = (st_reg.phase == 4'(DUTY_STEPS - 1)) ? '0 : st_reg.phase + 4'h1;
        end else begin
            st_next.stepDiv = st_reg.stepDiv + 16'h0001;
        end
        // Full code is high in every phase, zero code in none
        st_next.level = (st_reg.phase < dutyCode);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pwmLevel = st_reg.level;

endmodule // fpo_pwm_gen
